//--- logic/disk_read_regs.vh
`ifndef DISK_READ_REGS_VH
`define DISK_READ_REGS_VH

// Control select tag bus bits
`define BUS_WIDTH           10
`define BUS_READ_BIT        1
`define BUS_MARK_EN_BIT     4

// Clock period in picoseconds
`define CLOCK_PERIOD_PS     40000

// Timing figures in picoseconds
`define LOCK_TIME_PS        7750000
`define DETECT_TIME_PS      1700000
`define MARK_GAP_PS         2400000
`define PULSE_TIME_PS       10000

// Cycle counts, rounded up; the pulse count never below one cycle
`define CEIL_CYC(t)         (((t) + `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS)
`define LOCK_CYCLES         `CEIL_CYC(`LOCK_TIME_PS)
`define DETECT_CYCLES       `CEIL_CYC(`DETECT_TIME_PS)
`define PULSE_CYCLES        ((`CEIL_CYC(`PULSE_TIME_PS) < 1) ? 1 : `CEIL_CYC(`PULSE_TIME_PS))

`define TIMER_WIDTH         8

`endif

//--- logic/disk_read_mark_detect_sync.v
// What this block does
// - Tag with read bit on the bus enables the read detection path.
// - Decode read pulses into NRZ data, with read clock sent alongside.
// - Recognised address mark gap raises the mark-found output.
// - High-resolution edge latches low-resolution level; unqualified edges give nothing.
// - Lock-to-data high while its timer runs; triggered by gate drop or mark.
// - Gate inactive holds lock set; lock ends 7.75 us after gate returns.
// - A detected address mark fires a 7.75 us lock-to-data period.
// - Address mark is a gap of about 2.4 us without transitions.
// - Mark detection works only during reads, armed by bus bit 4.
// - While armed, each data pulse retriggers a 1.7 us data-detect timer.
// - First pulse after timer expiry flags the mark: lock and mark pulses.
// - Loop input takes servo clock unless reading data without mark enable.
// - Each selected input transition forms a short pulse for strobe and separator.
// - During lock, zeros-enable held set and ones-enable output suppressed.
`include "disk_read_regs.vh"
`default_nettype none

module disk_read_mark_detect_sync #(
    parameter LOCK_CYCLES   = `LOCK_CYCLES,
    parameter DETECT_CYCLES = `DETECT_CYCLES
) (
    input  wire                  clock,           // 25 MHz block clock
    input  wire                  resetn,          // Asynchronous reset, active low
    input  wire                  control_select,  // Control select tag from controller
    input  wire [`BUS_WIDTH-1:0] bus_out,         // Bus out bits from controller
    input  wire                  hi_res_cross,    // High-resolution zero-cross channel
    input  wire                  lo_res_cross,    // Low-resolution zero-cross channel
    input  wire                  servo_clock,     // Servo-derived reference clock
    input  wire                  data_window,     // Data window from loop oscillator
    input  wire                  loop_clock,      // Read clock from loop oscillator
    output reg                   read_enable_q,   // Read detection path enabled
    output reg                   nrz_data_q,      // NRZ read data to controller
    output reg                   read_clock_q,    // Read clock to controller
    output reg                   mark_found_q,    // Address mark found pulse
    output reg                   lock_to_data_q,  // Lock-to-data level
    output reg                   select_servo_q,  // Loop input is servo clock
    output reg                   loop_pulse_q     // Formed pulse to strobe delay
);

    localparam TW = `TIMER_WIDTH;
    localparam [TW-1:0] LOCK_LOAD   = LOCK_CYCLES[TW-1:0];
    localparam [TW-1:0] DETECT_LOAD = DETECT_CYCLES[TW-1:0];
    localparam integer  PULSE_CYC   = `PULSE_CYCLES;
    localparam [TW-1:0] PULSE_LOAD  = PULSE_CYC[TW-1:0];

    // Two-stage synchronisers; stage one is read only by stage two
    localparam NSYNC = 8;
    wire [NSYNC-1:0] raw_in;
    reg  [NSYNC-1:0] sync1_q;
    reg  [NSYNC-1:0] sync2_q;
    reg  [NSYNC-1:0] prev_q;
    assign raw_in = {loop_clock, data_window, servo_clock, lo_res_cross,
                     hi_res_cross, bus_out[`BUS_MARK_EN_BIT],
                     bus_out[`BUS_READ_BIT], control_select};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    prev_q[gi]  <= 1'b0;
                end else begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    prev_q[gi]  <= sync2_q[gi];
                end
            end
        end
    endgenerate

    wire tag_s    = sync2_q[0];
    wire rd_bit_s = sync2_q[1];
    wire am_bit_s = sync2_q[2];
    wire hi_rise  = sync2_q[3] & ~prev_q[3];
    wire lo_s     = sync2_q[4];
    wire servo_tr = sync2_q[5] ^ prev_q[5];
    wire window_s = sync2_q[6];
    wire clk_rise = sync2_q[7] & ~prev_q[7];

    wire read_gate = tag_s & rd_bit_s;
    wire mark_armed = read_gate & am_bit_s;

    wire data_pulse = hi_rise & lo_s & read_enable_q;

    wire use_servo = ~read_gate | mark_armed;
    wire sel_tr = use_servo ? servo_tr : data_pulse;

    reg [TW-1:0] lock_cnt_q;
    reg [TW-1:0] detect_cnt_q;
    reg [TW-1:0] mark_cnt_q;
    reg [TW-1:0] pulse_cnt_q;
    reg          seen_data_q;
    reg          ones_en_q;
    reg          zeros_en_q;
    reg [TW-1:0] lock_cnt_d;
    reg [TW-1:0] detect_cnt_d;
    reg [TW-1:0] mark_cnt_d;
    reg [TW-1:0] pulse_cnt_d;
    reg          seen_data_d;
    reg          ones_en_d;
    reg          zeros_en_d;
    reg          nrz_data_d;

    wire lock_run   = (lock_cnt_q != {TW{1'b0}});
    wire detect_run = (detect_cnt_q != {TW{1'b0}});
    wire mark_run   = (mark_cnt_q > {{(TW-1){1'b0}}, 1'b1});
    wire pulse_run  = (pulse_cnt_q > {{(TW-1){1'b0}}, 1'b1});

    wire mark_detect = mark_armed & data_pulse & seen_data_q & ~detect_run;
    // lock rises with the mark itself, so both outputs start together
    wire lock_d      = ~read_gate | mark_detect | lock_run;

    // read gate drives the detection path
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            read_enable_q  <= 1'b0;
            select_servo_q <= 1'b1;
        end else begin
            read_enable_q  <= read_gate;
            select_servo_q <= use_servo;
        end
    end

    always @* begin
        lock_cnt_d = lock_cnt_q;
        if (!read_gate) begin
            lock_cnt_d = LOCK_LOAD;
        end else if (mark_detect) begin
            lock_cnt_d = LOCK_LOAD;
        end else if (lock_run) begin
            lock_cnt_d = lock_cnt_q - 1'b1;
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lock_cnt_q <= {TW{1'b0}};
        end else begin
            lock_cnt_q <= lock_cnt_d;
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lock_to_data_q <= 1'b1;
        end else begin
            lock_to_data_q <= lock_d;
        end
    end

    always @* begin
        detect_cnt_d = detect_cnt_q;
        seen_data_d  = seen_data_q;
        if (!mark_armed) begin
            detect_cnt_d = {TW{1'b0}};
            seen_data_d  = 1'b0;
        end else if (data_pulse) begin
            detect_cnt_d = DETECT_LOAD;
            seen_data_d  = 1'b1;
        end else if (detect_run) begin
            detect_cnt_d = detect_cnt_q - 1'b1;
        end
    end

    // Arming alone is not a gap: a pulse must be seen first
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            detect_cnt_q <= {TW{1'b0}};
            seen_data_q  <= 1'b0;
        end else begin
            detect_cnt_q <= detect_cnt_d;
            seen_data_q  <= seen_data_d;
        end
    end

    // gap is timer expiry with no pulses
    always @* begin
        mark_cnt_d = mark_cnt_q;
        if (mark_detect) begin
            mark_cnt_d = LOCK_LOAD;
        end else if (mark_cnt_q != {TW{1'b0}}) begin
            mark_cnt_d = mark_cnt_q - 1'b1;
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mark_cnt_q <= {TW{1'b0}};
        end else begin
            mark_cnt_q <= mark_cnt_d;
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mark_found_q <= 1'b0;
        end else begin
            mark_found_q <= mark_detect | mark_run;
        end
    end

    always @* begin
        pulse_cnt_d = pulse_cnt_q;
        if (sel_tr) begin
            pulse_cnt_d = PULSE_LOAD;
        end else if (pulse_cnt_q != {TW{1'b0}}) begin
            pulse_cnt_d = pulse_cnt_q - 1'b1;
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pulse_cnt_q <= {TW{1'b0}};
        end else begin
            pulse_cnt_q <= pulse_cnt_d;
        end
    end

    // one clock is the shortest pulse this clock can form
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            loop_pulse_q <= 1'b0;
        end else begin
            loop_pulse_q <= sel_tr | pulse_run;
        end
    end

    // Data separator: a pulse on the cell edge opens the next cell, so none is lost
    always @* begin
        ones_en_d  = ones_en_q;
        zeros_en_d = zeros_en_q;
        nrz_data_d = nrz_data_q;
        if (clk_rise) begin
            nrz_data_d = ones_en_q & ~lock_d;
            ones_en_d  = sel_tr & window_s & ~lock_d;
            zeros_en_d = lock_d | sel_tr;
        end else if (lock_d) begin
            zeros_en_d = 1'b1;
            ones_en_d  = 1'b0;
        end else if (sel_tr) begin
            ones_en_d  = ones_en_q | window_s;
            zeros_en_d = 1'b1;
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ones_en_q  <= 1'b0;
            zeros_en_q <= 1'b1;
        end else begin
            ones_en_q  <= ones_en_d;
            zeros_en_q <= zeros_en_d;
        end
    end

    // NRZ bit changes only at a cell edge
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            nrz_data_q <= 1'b0;
        end else begin
            nrz_data_q <= nrz_data_d;
        end
    end

    // read clock follows loop oscillator, three clocks late
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            read_clock_q <= 1'b0;
        end else begin
            read_clock_q <= sync2_q[7];
        end
    end

endmodule // disk_read_mark_detect_sync

`default_nettype wire

//--- test/read_path_assertions.sv
`include "disk_read_regs.vh"
`default_nettype none
module read_path_assertions #(parameter LOCK_CYCLES = 10) (
    input wire logic clock, resetn, control_select, hi_res_cross, lo_res_cross, // Inputs
    input wire logic servo_clock, data_window, loop_clock,                      // Inputs
    input wire logic [`BUS_WIDTH-1:0] bus_out,                                  // Bus bits
    input wire logic read_enable_q, nrz_data_q, read_clock_q, mark_found_q,     // Outputs
    input wire logic lock_to_data_q, select_servo_q, loop_pulse_q               // Outputs
);
    int mark_len_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Counted, since the pulse is longer than a repetition may span
    always @(posedge clock or negedge resetn)
        if (!resetn) mark_len_q <= 0;
        else mark_len_q <= mark_found_q ? mark_len_q + 1 : 0;
    sequence lock_run;
        lock_to_data_q[*8] ##1 lock_to_data_q[*5];
    endsequence
    sequence lock_expires;
        lock_to_data_q[*8] ##[1:4] (!lock_to_data_q || !read_enable_q);
    endsequence
    read_gate_a: assert property ($rose(read_enable_q) |->
        $past(control_select && bus_out[`BUS_READ_BIT], 3)) else $error("read path without gate");
    lock_hold_a: assert property (!read_enable_q |-> lock_to_data_q)
        else $error("lock low while gate idle");
    servo_idle_a: assert property (!read_enable_q |-> select_servo_q)
        else $error("data selected while idle");
    lock_end_a: assert property ($rose(read_enable_q) |-> lock_expires)
        else $error("lock period wrong length");
    mark_len_a: assert property ($fell(mark_found_q) |-> mark_len_q == LOCK_CYCLES)
        else $error("mark pulse wrong length");
    mark_lock_a: assert property ($rose(mark_found_q) |-> lock_to_data_q)
        else $error("mark without lock");
    mark_armed_a: assert property ($rose(mark_found_q) |->
        $past(bus_out[`BUS_MARK_EN_BIT], 3)) else $error("mark while not armed");
    pulse_single_a: assert property (loop_pulse_q |=> !loop_pulse_q)
        else $error("loop pulse too long");
    nrz_zero_a: assert property (lock_run |-> !nrz_data_q)
        else $error("ones decoded during lock");
endmodule // read_path_assertions
bind disk_read_mark_detect_sync read_path_assertions #(.LOCK_CYCLES(LOCK_CYCLES)) chk_i (.*);
`default_nettype wire

//--- test/controller_model.sv
`include "disk_read_regs.vh"
`default_nettype none
module controller_model (
    input wire logic clock, read_req, mark_req, // Clock and bench requests
    output logic control_select,               // Tag to drive
    output logic [`BUS_WIDTH-1:0] bus_out      // Bus bits to drive
);
    timeunit 1ns;
    timeprecision 1ns;
    logic read_q = 1'b0;
    logic mark_q = 1'b0;
    logic read_seen_q = 1'b0;
    logic mark_seen_q = 1'b0;
    // Requests taken on the rising edge so falling-edge bench writes never race
    always @(posedge clock) begin
        read_seen_q <= read_req;
        mark_seen_q <= read_req & mark_req;
    end
    always @(negedge clock) begin
        read_q <= read_seen_q;
        mark_q <= mark_seen_q;
    end
    assign control_select = read_q;
    assign bus_out = (`BUS_WIDTH'(read_q) << `BUS_READ_BIT) | (`BUS_WIDTH'(mark_q) << `BUS_MARK_EN_BIT);
endmodule // controller_model
`default_nettype wire

//--- test/testbench.sv
`include "disk_read_regs.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LOCK = 10;
    logic clock = 0, resetn = 0, read_req = 0, mark_req = 0, hi_res_cross = 0;
    logic lo_res_cross = 0, servo_clock = 0, data_window = 1, loop_clock = 0, control_select;
    logic [`BUS_WIDTH-1:0] bus_out;
    wire logic read_enable_q, nrz_data_q, read_clock_q, mark_found_q, lock_to_data_q;
    wire logic select_servo_q, loop_pulse_q;
    int fail_count = 0, checks = 0, n;
    controller_model controller_model_i (.*);
    disk_read_mark_detect_sync #(.LOCK_CYCLES(LOCK), .DETECT_CYCLES(4)) disk_read_mark_detect_sync_i (.*);
    always #20 clock = ~clock;
    // Loop clock stands still outside reads
    always #160 if (read_enable_q) loop_clock = ~loop_clock;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic hit(input logic lo);
        @(negedge clock) lo_res_cross = lo;
        @(negedge clock) hi_res_cross = 1;
        @(negedge clock) hi_res_cross = 0;
        lo_res_cross = 0;
    endtask
    task automatic count_pulses(output int k);
        k = 0;
        repeat (6) @(negedge clock) k += loop_pulse_q;
    endtask
    task automatic read_start();
        @(negedge clock) read_req = 1;
        for (n = 0; n < 8 && !read_enable_q; n++) @(negedge clock);
        check(read_enable_q, 1);
        check(select_servo_q, 0);
        for (n = 0; n < 30 && lock_to_data_q; n++) @(negedge clock);
        check(n >= LOCK - 1 && n <= LOCK + 1, 1);
    endtask
    task automatic qualify();
        hit(0);
        count_pulses(n);
        check(n, 0);
        hit(1);
        count_pulses(n);
        check(n, 1);
        for (n = 0; n < 16 && !nrz_data_q; n++) @(negedge clock);
        check(nrz_data_q, 1);
        @(posedge loop_clock);
        repeat (4) @(negedge clock);
        check(read_clock_q, 1);
    endtask
    task automatic mark_find();
        @(negedge clock) mark_req = 1;
        repeat (4) @(negedge clock);
        check(select_servo_q, 1);
        repeat (3) hit(1);
        repeat (8) @(negedge clock);
        check(mark_found_q, 0);
        hit(1);
        for (n = 0; n < 8 && !mark_found_q; n++) @(negedge clock);
        check(mark_found_q, 1);
        check(lock_to_data_q, 1);
        mark_req = 0;
        repeat (LOCK + 4) @(negedge clock);
    endtask
    task automatic read_drop();
        @(negedge clock) read_req = 0;
        repeat (5) @(negedge clock);
        check(read_enable_q, 0);
        check(lock_to_data_q, 1);
        servo_clock = 1;
        count_pulses(n);
        check(n, 1);
    endtask
    task automatic complete_run();
        if (fail_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clock);
        resetn = 1;
        read_start();
        qualify();
        mark_find();
        read_drop();
        complete_run();
    end
    initial begin
        #40000;
        fail_count++;
        complete_run();
    end
endmodule // testbench
`default_nettype wire
